// ### rtl/tbpp_pkg.sv
/*
  tbpp_pkg: register map, field positions and reset values of the
  shared telecom-bus / line-interface input stage.
  assumes: byte-wide register port with 16-bit byte addresses.
*/
package tbpp_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          REG_W         = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [15:0] CTRL_ADDR     = 16'h013b;
  localparam logic [15:0] STAT_ADDR     = 16'h013c;

  // ****************************************
  // control byte fields
  // ****************************************
  localparam int          CTRL_ODD_BIT  = 0;   // 1: odd parity, 0: even
  localparam int          CTRL_WIDE_BIT = 1;   // 1: parity also covers markers
  localparam int          CTRL_FALL_BIT = 2;   // 1: line data on falling edge
  localparam int          CTRL_BUS_BIT  = 3;   // 1: telecom bus enabled
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CTRL_MASK     = 8'h0f;

  // ****************************************
  // status byte fields
  // ****************************************
  localparam int          STAT_PERR_BIT = 0;   // sticky, write 1 to clear
  localparam int          STAT_BUS_BIT  = 1;   // bus mode as seen by link side
  localparam logic [7:0]  STAT_RST      = 8'h00;

  localparam int          SYNC_STAGES   = 2;
  localparam int          CFG_W         = 4;

endpackage : tbpp_pkg

// ### rtl/tbpp_sync.sv
/*
  tbpp_sync: two-flop level synchroniser, W bits wide.
  assumes: each bit is a slow level, or the bits are quasi-static
  when sampled together.
*/
`timescale 1ns/1ps
module tbpp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) begin
      $error("tbpp_sync: W must be at least 1");
    end
  end

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // tbpp_sync

// ### rtl/tbpp_top.sv
/*
  tbpp_top: per-channel input stage on the two shared pins. in bus mode
  it takes the phase marker, payload marker, parity and data byte of
  the transmit telecom bus; in line mode it takes the recovered line
  clock and the positive/negative rail data from a line interface.
  assumes: the shared pins appear on two ports each (one per role), both
  driven from the same wire; mode is changed only while link clocks idle.
*/
//
// Function
// - shared pins act as telecom-bus inputs when bus enabled, else line inputs
// - parity input checked as even or odd parity over the data byte
// - optionally parity also covers payload marker and phase marker
// - parity scope and sense come from control byte register
// - line mode: framer samples positive and negative rails on line clock
// - in line mode the recovered line clock times all link-domain ingress logic of the channel
// - positive rail sampled on the software-selected line clock edge
// - bus qualifiers sampled on falling edge of transmit bus clock
`timescale 1ns/1ps
module tbpp_top #(
  parameter int DATA_W = 8
) (
  // core clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [15:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata_q,
  // telecom bus role
  input  wire logic              tx_bus_clock_in,
  input  wire logic [DATA_W-1:0] tx_bus_data_in,
  input  wire logic              payload_marker_in,
  input  wire logic              frame_phase_marker_in,
  input  wire logic              tx_bus_parity_in,
  // line interface role
  input  wire logic              rx_line_clock_in,
  input  wire logic              rx_pos_rail_in,
  input  wire logic              rx_neg_rail_in,
  // to framer, link clock domain
  output logic                   link_clk_out_q,
  output logic                   bus_byte_valid_q,
  output logic      [DATA_W-1:0] bus_byte_q,
  output logic                   bus_phase_q,
  output logic                   bus_payload_q,
  output logic                   line_valid_q,
  output logic                   line_pos_q,
  output logic                   line_neg_q,
  // status to core
  output logic                   parity_err_q
);

  initial begin
    if (DATA_W != 8) begin
      $error("tbpp_top: telecom bus byte must be 8 bits");
    end
    if (tbpp_pkg::CFG_W <= tbpp_pkg::CTRL_BUS_BIT) begin
      $error("tbpp_top: synchronised control field too narrow");
    end
  end

  // ****************************************
  // register port, core domain
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       perr_d;
  logic [7:0] rdata_d;
  logic       perr_evt;
  logic       link_bus_core;
  logic [7:0] stat_val;

  wire ctrl_hit  = (reg_addr == tbpp_pkg::CTRL_ADDR);
  wire stat_hit  = (reg_addr == tbpp_pkg::STAT_ADDR);
  wire perr_clr  = reg_wr && stat_hit && reg_wdata[tbpp_pkg::STAT_PERR_BIT];

  assign ctrl_d  = (reg_wr && ctrl_hit) ? (reg_wdata & tbpp_pkg::CTRL_MASK) : ctrl_q;
  // a mismatch in the clearing cycle survives the clear
  assign perr_d  = perr_evt ? 1'b1 : (perr_clr ? 1'b0 : parity_err_q);

  assign stat_val = {6'h00, link_bus_core, parity_err_q};
  assign rdata_d  = !reg_rd  ? reg_rdata_q :
                    ctrl_hit ? ctrl_q :
                    stat_hit ? stat_val : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= tbpp_pkg::CTRL_RST;
      parity_err_q <= 1'b0;
      reg_rdata_q  <= 8'h00;
    end else begin
      ctrl_q       <= ctrl_d;
      parity_err_q <= perr_d;
      reg_rdata_q  <= rdata_d;
    end
  end

  // ****************************************
  // link clock selection
  // ****************************************
  // the pin role decides the clock: bus clock inverted so that every
  // bus sample lands on its falling edge, or the line clock with the
  // chosen polarity. a plain mux: reconfigure only with clocks stopped.
  logic [3:0] cfg_link;
  wire        bus_en_raw = ctrl_q[tbpp_pkg::CTRL_BUS_BIT];
  wire        fall_raw   = ctrl_q[tbpp_pkg::CTRL_FALL_BIT];
  wire        link_clk   = bus_en_raw ? ~tx_bus_clock_in
                                      : (rx_line_clock_in ^ fall_raw);

  // quasi-static control byte into the link domain
  tbpp_sync #(.W(tbpp_pkg::CFG_W)) u_cfg_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     (ctrl_q[3:0]),
    .q     (cfg_link)
  );

  wire link_bus  = cfg_link[tbpp_pkg::CTRL_BUS_BIT];
  wire link_odd  = cfg_link[tbpp_pkg::CTRL_ODD_BIT];
  wire link_wide = cfg_link[tbpp_pkg::CTRL_WIDE_BIT];

  // ****************************************
  // link domain sampling and parity check
  // ****************************************
  function automatic logic exp_parity(input logic [7:0] data, input logic pl,
                                      input logic ph, input logic wide, input logic odd);
    logic p;
    p = ^data ^ (wide ? (pl ^ ph) : 1'b0);
    exp_parity = odd ? ~p : p;
  endfunction

  wire par_exp = exp_parity(tx_bus_data_in, payload_marker_in, frame_phase_marker_in,
                            link_wide, link_odd);
  // the synchronised enable lags a mode change by two link edges; the raw
  // enable, static while link clocks idle and already steering the link
  // clock, keeps those stale edges from checking line data as parity
  wire par_bad = bus_en_raw && link_bus && (par_exp != tx_bus_parity_in);

  logic              perr_tgl_q;
  logic              link_div_q;

  // next values of the link-domain samples
  logic              bus_valid_d;
  logic [DATA_W-1:0] bus_byte_d;
  logic              bus_phase_d;
  logic              bus_payload_d;
  logic              line_valid_d;
  logic              line_pos_d;
  logic              line_neg_d;
  logic              perr_tgl_d;

  // phase marker passed on as sampled; the source owns its timing
  assign bus_valid_d   = link_bus;
  assign bus_byte_d    = link_bus ? tx_bus_data_in : '0;
  assign bus_phase_d   = link_bus && frame_phase_marker_in;
  assign bus_payload_d = link_bus && payload_marker_in;
  assign line_valid_d  = !link_bus;
  assign line_pos_d    = !link_bus && rx_pos_rail_in;
  assign line_neg_d    = !link_bus && rx_neg_rail_in;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_byte_valid_q <= 1'b0;
      bus_byte_q       <= '0;
      bus_phase_q      <= 1'b0;
      bus_payload_q    <= 1'b0;
      line_valid_q     <= 1'b0;
      line_pos_q       <= 1'b0;
      line_neg_q       <= 1'b0;
      perr_tgl_q       <= 1'b0;
      link_div_q       <= 1'b0;
    end else begin
      bus_byte_valid_q <= bus_valid_d;
      bus_byte_q       <= bus_byte_d;
      bus_phase_q      <= bus_phase_d;
      bus_payload_q    <= bus_payload_d;
      line_valid_q     <= line_valid_d;
      line_pos_q       <= line_pos_d;
      line_neg_q       <= line_neg_d;
      perr_tgl_q       <= perr_tgl_d;
      link_div_q       <= ~link_div_q;
    end
  end

  assign link_clk_out_q = link_div_q;

  // ****************************************
  // crossings back to core
  // ****************************************
  // a toggle carries a mismatch to the core and its echo returns before
  // the next toggle is sent, so two flips never cancel between core
  // samples; mismatches in flight merge, which a sticky flag tolerates
  logic [1:0] back_sync;
  logic       tgl_seen_q;

  tbpp_sync #(.W(2)) u_back_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({link_bus, perr_tgl_q}),
    .q     (back_sync)
  );

  assign link_bus_core = back_sync[1];
  assign perr_evt      = back_sync[0] ^ tgl_seen_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= back_sync[0];
    end
  end

  // echo of the core's seen toggle, back in the link domain
  logic perr_ack_link;

  tbpp_sync #(.W(1)) u_ack_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     (tgl_seen_q),
    .q     (perr_ack_link)
  );

  wire perr_busy = perr_tgl_q ^ perr_ack_link;
  assign perr_tgl_d = perr_tgl_q ^ (par_bad && !perr_busy);

endmodule // tbpp_top

// ### bench/tbpp_sva.sv
/* tbpp_sva: port-level checker for tbpp_top.
   assumes: bound into tbpp_top; control is changed only through the
   register port, and link clocks idle while the mode changes. */
`timescale 1ns/1ps
module tbpp_sva #(parameter int DATA_W = 8) (
  // core side
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              parity_err_q,
  input wire logic [15:0]       reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata_q,
  // link side
  input wire logic              tx_bus_clock_in,
  input wire logic              frame_phase_marker_in,
  input wire logic              payload_marker_in,
  input wire logic              rx_line_clock_in,
  input wire logic              rx_pos_rail_in,
  input wire logic              rx_neg_rail_in,
  input wire logic [DATA_W-1:0] tx_bus_data_in,
  input wire logic [DATA_W-1:0] bus_byte_q,
  input wire logic              bus_byte_valid_q,
  input wire logic              bus_phase_q,
  input wire logic              bus_payload_q,
  input wire logic              line_valid_q,
  input wire logic              line_pos_q,
  input wire logic              line_neg_q,
  input wire logic              link_clk_out_q
);
  logic [7:0] ctrl_q;
  wire        clr = reg_wr && reg_addr == tbpp_pkg::STAT_ADDR && reg_wdata[0];
  wire        fall = ctrl_q[tbpp_pkg::CTRL_FALL_BIT];
  // bus-mode shadow gates the line checks: the phase marker shares that pin
  wire        busm = ctrl_q[tbpp_pkg::CTRL_BUS_BIT];
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) ctrl_q <= tbpp_pkg::CTRL_RST;
    else if (reg_wr && reg_addr == tbpp_pkg::CTRL_ADDR) ctrl_q <= reg_wdata & tbpp_pkg::CTRL_MASK;
  AST_BUS_BYTE: assert property (@(negedge tx_bus_clock_in) disable iff (!rst_n)
    bus_byte_valid_q ##1 bus_byte_valid_q |-> bus_byte_q == $past(tx_bus_data_in))
    else $error("bus byte differs from sampled data");
  AST_BUS_PHASE: assert property (@(negedge tx_bus_clock_in) disable iff (!rst_n)
    bus_byte_valid_q ##1 bus_byte_valid_q |-> bus_phase_q == $past(frame_phase_marker_in))
    else $error("phase output differs from sampled marker");
  AST_LINE_RISE: assert property (@(posedge rx_line_clock_in)
    disable iff (!rst_n || fall || busm)
    line_valid_q ##1 line_valid_q |-> line_pos_q == $past(rx_pos_rail_in))
    else $error("rail not taken on rising edge");
  AST_LINE_FALL: assert property (@(negedge rx_line_clock_in)
    disable iff (!rst_n || !fall || busm)
    line_valid_q ##1 line_valid_q |-> line_pos_q == $past(rx_pos_rail_in))
    else $error("rail not taken on falling edge");
  AST_MODE_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(bus_byte_valid_q && line_valid_q)) else $error("both pin roles active");
  AST_RD_CTRL: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == tbpp_pkg::CTRL_ADDR |=> reg_rdata_q == $past(ctrl_q))
    else $error("control readback wrong");
  AST_RD_STAT: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == tbpp_pkg::STAT_ADDR |=> reg_rdata_q[0] == $past(parity_err_q))
    else $error("status error bit differs from flag");
  AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata_q)) else $error("read data moved without read");
  AST_PERR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    parity_err_q && !clr |=> parity_err_q) else $error("parity flag dropped uncleared");
  AST_BUS_PAYLOAD: assert property (@(negedge tx_bus_clock_in) disable iff (!rst_n)
    bus_byte_valid_q ##1 bus_byte_valid_q |-> bus_payload_q == $past(payload_marker_in))
    else $error("payload output differs from sampled marker");
  AST_LINE_NEG: assert property (@(posedge rx_line_clock_in)
    disable iff (!rst_n || fall || busm)
    line_valid_q ##1 line_valid_q |-> line_neg_q == $past(rx_neg_rail_in))
    else $error("negative rail not taken on line clock");
  AST_LINK_TICK: assert property (@(negedge tx_bus_clock_in) disable iff (!rst_n)
    bus_byte_valid_q ##1 bus_byte_valid_q |-> link_clk_out_q != $past(link_clk_out_q))
    else $error("link clock indicator missed a bus edge");
endmodule // tbpp_sva
bind tbpp_top tbpp_sva #(.DATA_W(DATA_W)) chk (.core_clk, .rst_n, .reg_wr, .reg_rd,
  .parity_err_q, .reg_addr, .reg_wdata, .reg_rdata_q, .tx_bus_clock_in,
  .frame_phase_marker_in, .payload_marker_in, .rx_line_clock_in, .rx_pos_rail_in,
  .rx_neg_rail_in, .tx_bus_data_in, .bus_byte_q, .bus_byte_valid_q, .bus_phase_q,
  .bus_payload_q, .line_valid_q, .line_pos_q, .line_neg_q, .link_clk_out_q);

// ### bench/tbpp_partner.sv
/* tbpp_partner: upstream bus source or line interface on the shared pins.
   assumes: bench stops it (run low) before any mode change. */
`timescale 1ns/1ps
module tbpp_partner (
  // control from bench
  input wire logic   run,
  input wire logic   bus,
  input wire logic   wide,
  input wire logic   odd,
  input wire logic   bad,
  // pins
  output logic       bclk,
  output logic       pl,
  output logic       pin_a,
  output logic       pin_b,
  output logic       neg,
  output logic [7:0] data
);
  int cnt = 0;
  initial begin
    {bclk, pl, pin_a, pin_b, neg, data} = '0;
    forever
      if (!run) begin
        // released lines wander; clocks stand still between frames
        #3 {data, pl, pin_b, neg} = ~{data, pl, pin_b, neg};
      end else if (bus) begin
        bclk = 1'b1;
        #1.5 cnt = (cnt + 1) % 90;
        data = 8'($urandom);
        pl = cnt > 2;
        pin_a = cnt == 0 || cnt == 10;
        pin_b = ^data ^ (wide & (pl ^ pin_a)) ^ odd ^ (bad && cnt == 45);
        #1.5 bclk = 1'b0;
        #3;
      end else begin
        pin_a = 1'b1;
        #1.5 {pin_b, neg} = 2'($urandom);
        #1.5 pin_a = 1'b0;
        #3;
      end
  end
endmodule // tbpp_partner

// ### bench/testbench.sv
/* testbench: register port driver plus far-side pin model for tbpp_top.
   assumes: reads are compared against a queue of expected bytes. */
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] CA = tbpp_pkg::CTRL_ADDR, SA = tbpp_pkg::STAT_ADDR;
  logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic        run = 0, bus = 0, wide = 0, odd = 0, bad = 0;
  logic        bclk, pl, pin_a, pin_b, neg, link_clk_out_q, bus_byte_valid_q;
  logic        bus_phase_q, bus_payload_q, line_valid_q, line_pos_q, line_neg_q, parity_err_q;
  logic [15:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0, reg_rdata_q, data, bus_byte_q, c, e, exp_q[$];
  int          n_fail = 0, checks = 0;
  always #50 core_clk = ~core_clk;
  tbpp_partner far (.run, .bus, .wide, .odd, .bad, .bclk, .pl, .pin_a, .pin_b, .neg, .data);
  tbpp_top uut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
    .tx_bus_clock_in(bclk), .tx_bus_data_in(data), .payload_marker_in(pl),
    .frame_phase_marker_in(pin_a), .tx_bus_parity_in(pin_b), .rx_line_clock_in(pin_a),
    .rx_pos_rail_in(pin_b), .rx_neg_rail_in(neg), .link_clk_out_q, .bus_byte_valid_q,
    .bus_byte_q, .bus_phase_q, .bus_payload_q, .line_valid_q, .line_pos_q, .line_neg_q,
    .parity_err_q);
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(negedge core_clk) {reg_addr, reg_rd} = {a, 1'b1};
    exp_q.push_back(x);
    @(negedge core_clk) reg_rd = 1'b0;
  endtask
  // settle time covers the link-to-core crossing of flags
  task automatic go(input int n);
    run = 1'b1;
    repeat (n) @(negedge core_clk);
    run = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) if (reg_rd === 1'b1) begin
    @(negedge core_clk);
    e = exp_q.pop_front();
    checks++;
    if (reg_rdata_q !== e) begin
      n_fail++;
      $display("[ERR] reg_rdata_q expected %h seen %h", e, reg_rdata_q);
    end
  end
  initial begin
    #400000 n_fail++;
    final_report();
  end
  initial begin
    void'($urandom(44268));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    rd(CA, tbpp_pkg::CTRL_RST);
    rd(SA, tbpp_pkg::STAT_RST);
    wr(16'h013d, 8'hff);
    rd(16'h013d, 8'h00);
    rd(CA, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {wide, odd, bus} = {2'(i), 1'b0};
      c = {4'($urandom), 1'b0, 1'(i), 2'b00};
      wr(CA, c);
      rd(CA, c & tbpp_pkg::CTRL_MASK);
      go(10);
      rd(SA, 8'h00);
      c = {4'($urandom), 2'b10, 2'(i)};
      bus = 1'b1;
      wr(CA, c);
      rd(CA, c & tbpp_pkg::CTRL_MASK);
      go(20);
      rd(SA, 8'h02);
      bad = 1'b1;
      go(20);
      bad = 1'b0;
      rd(SA, 8'h03);
      wr(SA, 8'h01);
      rd(SA, 8'h02);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule // testbench
